// ---- design/hbc_pkg.sv ----
// Purpose: shared constants of the h-bridge control and supply supervision block
// Assumes: 20 MHz core clock, 16-bit serial frames on a separate link clock
// Notes: all offsets, field positions, reset values and timing counts live here
//
// Summary of operation
// [R1] derate mode: blanked limit, halve on warning
// [R2] derate off: half threshold from start
// [R3] active limit regulates after overcurrent trip
// [R4] limit off: overcurrent only sets flag
// [R5] enable bit gates outputs by wake/shutoff
// [R6] enable clear: ignore inputs, tristate legs; full-mode overvoltage still turns both high sides on
// [R7] bridge mode selects full or half decode
// [R8] input source picks soft bits or pins
// [R9] soft bits act as drive pins a/b
// [R10] half mode: no limit, ov warns, per-leg short
// [R11] filtered undervoltage turns all switches off
// [R12] restart only after filtered good supply
// [R13] filtered overvoltage sets supply-high flag
// [R14] full-mode overvoltage: both high sides on
// [R15] ov recovery resumes; flag held until clear
// [R16] frame: write bit, two register select bits
// [R17] flags clear on event once fault gone
// [R18] cap and edge speed fields passed through
// [R19] filters are restarting clock-cycle counters
package hbc_pkg;
    // ************************************************
    // timing
    // ************************************************
    localparam int CLK_NS = 50;
    localparam int UV_FILT_NS = 10000; // longest time, rounds down
    localparam int UV_FILT_CYC = (UV_FILT_NS / CLK_NS < 1) ? 1 : UV_FILT_NS / CLK_NS;
    localparam int OV_FILT_NS = 3000; // longest time, rounds down
    localparam int OV_FILT_CYC = (OV_FILT_NS / CLK_NS < 1) ? 1 : OV_FILT_NS / CLK_NS;
    localparam int BLANK_NS = 32000; // least time, rounds up
    localparam int BLANK_CYC = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 10;
    // ************************************************
    // serial frame
    // ************************************************
    localparam int FRAME_W = 16;
    localparam logic [3:0] LAST_BIT = 4'hF;
    localparam int WR_BIT = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 13;
    localparam logic [1:0] ADDR_ID = 2'h0;
    localparam logic [1:0] ADDR_STATUS = 2'h1;
    localparam logic [1:0] ADDR_MASK = 2'h2;
    localparam logic [1:0] ADDR_CFG = 2'h3;
    localparam logic [3:0] ID_REV = 4'h0; // arbitrary value
    localparam int ID_MARK = 4;
    // ************************************************
    // bridge_configuration_control fields
    // ************************************************
    localparam int CFG_W = 13;
    localparam logic [CFG_W-1:0] CFG_RESET = 13'h0D98;
    localparam int CFG_OPEN_CHECK = 12;
    localparam int CFG_THERMAL_DERATE_MODE = 11;
    localparam int CFG_ACTIVE_LIMIT_ENABLE = 10;
    localparam int CFG_CURRENT_CAP_SELECT_HI = 9;
    localparam int CFG_CURRENT_CAP_SELECT_LO = 8;
    localparam int CFG_EDGE_SPEED_SELECT_2 = 7;
    localparam int CFG_EDGE_SPEED_SELECT_0 = 5;
    localparam int CFG_OUTPUT_ENABLE = 4;
    localparam int CFG_BRIDGE_MODE = 3;
    localparam int CFG_INPUT_SOURCE = 2;
    localparam int CFG_SOFT_DRIVE_B = 1;
    localparam int CFG_SOFT_DRIVE_A = 0;
    // ************************************************
    // status flag positions
    // ************************************************
    localparam int ST_W = 12;
    localparam int ST_FRAME_ERR = 11;
    localparam int ST_UNDERVOLT = 9;
    localparam int ST_SUPPLY_HIGH = 8;
    localparam int ST_SHORT_B = 5;
    localparam int ST_SHORT_A = 4;
    localparam int ST_CURRENT_LIMIT_HIT = 2;
    localparam int ST_HEAT_WARNING = 1;
    // ************************************************
    // synchroniser lanes
    // ************************************************
    localparam int SY_WAKE = 0;
    localparam int SY_SHUTOFF = 1;
    localparam int SY_DRIVE_A = 2;
    localparam int SY_DRIVE_B = 3;
    localparam int SY_UV = 4;
    localparam int SY_OV = 5;
    localparam int SY_OC = 6;
    localparam int SY_WARN = 7;
    localparam int SY_SHORT_A = 8;
    localparam int SY_SHORT_B = 9;
    localparam int SY_FRAME = 10;
    localparam int SY_W = 11;
endpackage : hbc_pkg

// ---- design/hbc_sync.sv ----
// Purpose: three-stage synchroniser for a vector of independent levels
// Assumes: each lane is a slow level, not a bus word
// Notes: a lane changes once stages two and three agree
`timescale 1ns/10ps
module hbc_sync #(
    parameter int W = 1
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] stable_out
);
    import hbc_pkg::*;
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] stable_next;

    // per-lane agreement of stages two and three
    assign stable_next = (s2_reg & s3_reg) | (stable_out & (s2_reg | s3_reg));

    // stage one feeds stage two only, never logic
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            stable_out <= '0;
        end else begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            stable_out <= stable_next;
        end
    end
endmodule : hbc_sync

// ---- design/hbc_filter.sv ----
// Purpose: restarting time filter on a comparator level
// Assumes: level_in is already synchronised
// Notes: output follows input after it held the new level for the count
`timescale 1ns/10ps
module hbc_filter #(
    parameter int SET_CYC = 1,
    parameter int CLR_CYC = 1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic level_in,
    output logic filt_out
);
    import hbc_pkg::*;
    localparam logic [CNT_W-1:0] SET_M1 = CNT_W'(SET_CYC - 1);
    localparam logic [CNT_W-1:0] CLR_M1 = CNT_W'(CLR_CYC - 1);
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] cnt_next;
    logic filt_next;
    wire differ = level_in != filt_out;
    wire [CNT_W-1:0] target = level_in ? SET_M1 : CLR_M1;
    wire done = differ && (cnt_reg == target);

    // any return to the held level restarts the count [R19]
    assign cnt_next = (!differ || done) ? '0 : cnt_reg + 1'b1; // [R19]
    assign filt_next = done ? level_in : filt_out; // [R12]

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cnt_reg <= '0;
            filt_out <= RST_VAL;
        end else begin
            cnt_reg <= cnt_next;
            filt_out <= filt_next;
        end
    end
endmodule : hbc_filter

// ---- design/hbc_top.sv ----
// Purpose: configuration, input decode and supply supervision of the bridge
// Assumes: serial link on its own clock, comparators and pins asynchronous
// Notes: leg outputs are switch enables; both low means high impedance
`timescale 1ns/10ps
module hbc_top (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic sclk_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    input wire logic wake_pin_in,
    input wire logic shutoff_pin_in,
    input wire logic drive_pin_a_in,
    input wire logic drive_pin_b_in,
    input wire logic uv_cmp_in,
    input wire logic ov_cmp_in,
    input wire logic oc_cmp_in,
    input wire logic heat_warning_state_in,
    input wire logic short_a_in,
    input wire logic short_b_in,
    output logic leg_a_hs_out,
    output logic leg_a_ls_out,
    output logic leg_b_hs_out,
    output logic leg_b_ls_out,
    output logic half_threshold_out,
    output logic [1:0] current_cap_threshold_out,
    output logic [2:0] edge_speed_out,
    output logic fault_pin_n_out
);
    import hbc_pkg::*;

    // ************************************************
    // link domain: frame shifter
    // ************************************************
    logic [3:0] bit_cnt_reg;
    logic [FRAME_W-1:0] shift_reg;
    logic [FRAME_W-1:0] frame_word_reg;
    logic frame_tgl_reg;
    logic [FRAME_W-1:0] reply_reg;
    wire link_rst_n = resetn_in & ~spi_cs_n_in;
    wire frame_done = bit_cnt_reg == LAST_BIT;
    wire [3:0] miso_idx = LAST_BIT - bit_cnt_reg;
    wire [FRAME_W-1:0] word_in = {shift_reg[FRAME_W-2:0], spi_mosi_in};

    // bit count restarts whenever select is high, so a short frame is dropped
    always_ff @(posedge sclk_in or negedge link_rst_n) begin
        if (!link_rst_n) begin
            bit_cnt_reg <= 4'h0;
        end else begin
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
        end
    end

    // reply_reg only changes after a frame, so it is still while shifting out
    always_ff @(posedge sclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            shift_reg <= '0;
            spi_miso_out <= 1'b0;
        end else begin
            shift_reg <= word_in;
            spi_miso_out <= reply_reg[miso_idx];
        end
    end

    // whole word held still until the next frame ends; toggle marks it
    always_ff @(posedge sclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_word_reg <= '0;
            frame_tgl_reg <= 1'b0;
        end else if (frame_done) begin
            frame_word_reg <= word_in;
            frame_tgl_reg <= ~frame_tgl_reg;
        end
    end

    // ************************************************
    // core domain: synchronisers and filters
    // ************************************************
    logic [SY_W-1:0] raw_vec;
    logic [SY_W-1:0] sy_vec;
    always_comb begin
        raw_vec = '0;
        raw_vec[SY_WAKE] = wake_pin_in;
        raw_vec[SY_SHUTOFF] = shutoff_pin_in;
        raw_vec[SY_DRIVE_A] = drive_pin_a_in;
        raw_vec[SY_DRIVE_B] = drive_pin_b_in;
        raw_vec[SY_UV] = uv_cmp_in;
        raw_vec[SY_OV] = ov_cmp_in;
        raw_vec[SY_OC] = oc_cmp_in;
        raw_vec[SY_WARN] = heat_warning_state_in;
        raw_vec[SY_SHORT_A] = short_a_in;
        raw_vec[SY_SHORT_B] = short_b_in;
        raw_vec[SY_FRAME] = frame_tgl_reg;
    end

    hbc_sync #(.W(SY_W)) u_sync (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .async_in(raw_vec),
        .stable_out(sy_vec)
    );

    wire wake_s = sy_vec[SY_WAKE];
    wire shut_s = sy_vec[SY_SHUTOFF];
    wire oc_s = sy_vec[SY_OC];
    wire warn_s = sy_vec[SY_WARN];
    wire short_a_s = sy_vec[SY_SHORT_A];
    wire short_b_s = sy_vec[SY_SHORT_B];
    logic uv_lock;
    logic ov_cond;

    // lockout starts set: outputs wait for a filtered good supply [R11] [R12]
    hbc_filter #(.SET_CYC(UV_FILT_CYC), .CLR_CYC(UV_FILT_CYC), .RST_VAL(1'b1)) u_uv_filt (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in(sy_vec[SY_UV]),
        .filt_out(uv_lock)
    );

    // overvoltage ends as soon as the comparator drops [R13] [R15]
    hbc_filter #(.SET_CYC(OV_FILT_CYC), .CLR_CYC(1), .RST_VAL(1'b0)) u_ov_filt (
        .clk_in(clk_in),
        .resetn_in(resetn_in),
        .level_in(sy_vec[SY_OV]),
        .filt_out(ov_cond)
    );

    // ************************************************
    // frame decode
    // ************************************************
    logic frame_seen_reg;
    logic [CFG_W-1:0] cfg_reg;
    logic [CFG_W-1:0] cfg_next;
    logic [FRAME_W-1:0] reply_next;
    wire frame_evt = sy_vec[SY_FRAME] ^ frame_seen_reg;
    wire is_wr = frame_word_reg[WR_BIT]; // [R16]
    wire [1:0] addr = frame_word_reg[ADDR_HI:ADDR_LO]; // [R16]
    wire cfg_wr = frame_evt && is_wr && (addr == ADDR_CFG); // [R16]
    wire st_wr = frame_evt && is_wr && (addr == ADDR_STATUS);
    wire frm_set = frame_evt && is_wr && (addr == ADDR_ID);
    assign cfg_next = cfg_wr ? frame_word_reg[CFG_W-1:0] : cfg_reg; // [R18]

    wire derate = cfg_reg[CFG_THERMAL_DERATE_MODE];
    wire act_lim = cfg_reg[CFG_ACTIVE_LIMIT_ENABLE];
    wire out_en = cfg_reg[CFG_OUTPUT_ENABLE];
    wire full_mode = cfg_reg[CFG_BRIDGE_MODE];
    wire soft_src = cfg_reg[CFG_INPUT_SOURCE];

    // ************************************************
    // fault flags
    // ************************************************
    logic [ST_W-1:0] flags_reg;
    logic [ST_W-1:0] flags_next;
    logic [ST_W-1:0] flag_now;
    logic [ST_W-1:0] flag_set;
    logic wake_prev_reg;
    logic shut_prev_reg;
    always_comb begin
        flag_now = '0;
        flag_now[ST_UNDERVOLT] = uv_lock;
        flag_now[ST_SUPPLY_HIGH] = ov_cond; // [R13]
        flag_now[ST_SHORT_A] = short_a_s;
        flag_now[ST_SHORT_B] = short_b_s;
        flag_now[ST_CURRENT_LIMIT_HIT] = oc_s; // [R4]
        flag_set = flag_now;
        flag_set[ST_FRAME_ERR] = frm_set;
    end

    // wake rising or shutoff falling clears every flag whose fault is gone [R17]
    wire clr_evt = (wake_s && !wake_prev_reg) || (!shut_s && shut_prev_reg); // [R17]
    wire [ST_W-1:0] st_clr = st_wr ? frame_word_reg[ST_W-1:0] : '0;
    wire [ST_W-1:0] clr_vec = (clr_evt ? '1 : st_clr) & ~flag_now; // [R17]
    // a set in the clearing cycle wins; supply-high is held until cleared [R15]
    assign flags_next = flag_set | (flags_reg & ~clr_vec); // [R15]

    always_comb begin
        reply_next = '0;
        reply_next[ADDR_HI:ADDR_LO] = addr;
        case (addr)
            ADDR_ID: begin
                reply_next[ID_MARK] = 1'b1;
                reply_next[3:0] = ID_REV;
            end
            ADDR_STATUS: begin
                reply_next[ST_W-1:0] = flags_reg;
                reply_next[ST_HEAT_WARNING] = warn_s;
            end
            ADDR_CFG: begin
                reply_next[CFG_W-1:0] = cfg_reg;
            end
            default: begin
                reply_next[ADDR_HI:ADDR_LO] = addr;
            end
        endcase
    end

    // ************************************************
    // current limit blanking
    // ************************************************
    localparam logic [CNT_W-1:0] BLANK_LD = CNT_W'(BLANK_CYC);
    logic [CNT_W-1:0] blank_cnt_reg;
    logic [CNT_W-1:0] blank_next;
    wire chop = blank_cnt_reg != '0;
    // regulation only in full mode with active limit set [R3] [R10]
    wire lim_start = act_lim && full_mode && oc_s && !chop; // [R3] [R4] [R10]
    assign blank_next = lim_start ? BLANK_LD : (chop ? blank_cnt_reg - 1'b1 : '0); // [R1]

    // ************************************************
    // input decode and leg drive
    // ************************************************
    // soft bits stand in for the pins one to one [R8] [R9]
    wire in_a = soft_src ? cfg_reg[CFG_SOFT_DRIVE_A] : sy_vec[SY_DRIVE_A]; // [R8] [R9]
    wire in_b = soft_src ? cfg_reg[CFG_SOFT_DRIVE_B] : sy_vec[SY_DRIVE_B]; // [R8] [R9]
    // full mode: b low freewheels high, else a picks direction [R7]
    wire lvl_a = full_mode ? (!in_b || in_a) : in_a; // [R7]
    wire lvl_b = full_mode ? (!in_b || !in_a) : in_b; // [R7]
    wire en_ok = out_en && wake_s && !shut_s; // [R5] [R6]
    wire sc_flag_a = flags_reg[ST_SHORT_A];
    wire sc_flag_b = flags_reg[ST_SHORT_B];
    // short latches off both legs in full mode, its own leg in half mode [R10]
    wire off_all = !en_ok || uv_lock || chop || (full_mode && (sc_flag_a || sc_flag_b)); // [R6] [R11]
    wire off_a = off_all || sc_flag_a; // [R10]
    wire off_b = off_all || sc_flag_b; // [R10]
    // recirculation overrides inputs but never an undervoltage lockout [R14]
    wire ov_full = ov_cond && full_mode && !uv_lock; // [R14] [R10]
    wire hs_a = ov_full || (!off_a && lvl_a);
    wire ls_a = !ov_full && !off_a && !lvl_a;
    wire hs_b = ov_full || (!off_b && lvl_b);
    wire ls_b = !ov_full && !off_b && !lvl_b;
    wire half_next = !derate || warn_s; // [R1] [R2]
    wire fault_n_next = !((|flags_reg) || shut_s);

    // core state
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            frame_seen_reg <= 1'b0;
            cfg_reg <= CFG_RESET;
            flags_reg <= '0;
            wake_prev_reg <= 1'b0;
            shut_prev_reg <= 1'b0;
            blank_cnt_reg <= '0;
        end else begin
            frame_seen_reg <= sy_vec[SY_FRAME];
            cfg_reg <= cfg_next;
            flags_reg <= flags_next;
            wake_prev_reg <= wake_s;
            shut_prev_reg <= shut_s;
            blank_cnt_reg <= blank_next;
        end
    end

    // reply snapshot taken per frame for the next one to shift out
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reply_reg <= '0;
        end else if (frame_evt) begin
            reply_reg <= reply_next;
        end
    end

    // registered outputs toward the power stage
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            leg_a_hs_out <= 1'b0;
            leg_a_ls_out <= 1'b0;
            leg_b_hs_out <= 1'b0;
            leg_b_ls_out <= 1'b0;
            half_threshold_out <= 1'b0;
            current_cap_threshold_out <= 2'h0;
            edge_speed_out <= 3'h0;
            fault_pin_n_out <= 1'b1;
        end else begin
            leg_a_hs_out <= hs_a;
            leg_a_ls_out <= ls_a;
            leg_b_hs_out <= hs_b;
            leg_b_ls_out <= ls_b;
            half_threshold_out <= half_next;
            current_cap_threshold_out <= cfg_reg[CFG_CURRENT_CAP_SELECT_HI:CFG_CURRENT_CAP_SELECT_LO]; // [R18]
            edge_speed_out <= cfg_reg[CFG_EDGE_SPEED_SELECT_2:CFG_EDGE_SPEED_SELECT_0]; // [R18]
            fault_pin_n_out <= fault_n_next;
        end
    end

    // ************************************************
    // assertions
    // ************************************************
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!resetn_in);
    wire legs_idle = !leg_a_hs_out && !leg_a_ls_out && !leg_b_hs_out && !leg_b_ls_out;

    AST_DERATE_HALF: assert property (derate && warn_s ##1 derate && warn_s |-> half_threshold_out) // [R1]
        else $error("warning did not halve the limit");
    AST_NO_DERATE: assert property (!derate ##1 !derate |-> half_threshold_out) // [R2]
        else $error("half threshold missing with derate off");
    AST_LIMIT_CHOP: assert property (lim_start |-> ##2 legs_idle [*8]) // [R3]
        else $error("legs driven during blanking");
    AST_LIMIT_OFF: assert property ((!act_lim || !full_mode) && !chop |=> !chop) // [R4]
        else $error("limiting started while disabled");
    AST_OC_FLAG: assert property (oc_s |=> flags_reg[ST_CURRENT_LIMIT_HIT]) // [R4]
        else $error("overcurrent flag not set");
    AST_EN_GATE: assert property ((!en_ok || uv_lock) && !ov_full |=> legs_idle) // [R5]
        else $error("legs driven while gated off");
    AST_FULL_FREEWHEEL: assert property (full_mode && !in_b && !off_all |=> leg_a_hs_out && leg_b_hs_out) // [R7]
        else $error("freewheel high decode wrong");
    AST_UV_OFF: assert property (uv_lock |=> legs_idle) // [R11]
        else $error("switch on during undervoltage");
    AST_OV_RECIRC: assert property (ov_cond && full_mode && !uv_lock |=> leg_a_hs_out && leg_b_hs_out // [R14]
        && !leg_a_ls_out && !leg_b_ls_out)
        else $error("no high side recirculation");
    AST_OV_HOLD: assert property (flags_reg[ST_SUPPLY_HIGH] && !clr_evt && !st_wr |=> // [R15]
        flags_reg[ST_SUPPLY_HIGH])
        else $error("supply high flag lost");
    AST_CLEAR: assert property (clr_evt && !flag_set[ST_SUPPLY_HIGH] |=> !flags_reg[ST_SUPPLY_HIGH]) // [R17]
        else $error("flag not cleared");
    AST_CFG_WR: assert property (cfg_wr |-> ##2 edge_speed_out == // [R18]
        $past(cfg_next[CFG_EDGE_SPEED_SELECT_2:CFG_EDGE_SPEED_SELECT_0], 2))
        else $error("edge speed not passed through");

    COV_LIMIT: cover property (lim_start);
    COV_OV_FULL: cover property (ov_full ##1 !ov_cond);
    COV_CFG_WR: cover property (cfg_wr);
    COV_CLEAR: cover property (clr_evt && |flags_reg);
endmodule : hbc_top

// ---- verification/hbc_host.sv ----
// Purpose: host model on the serial link of the bridge block
// Assumes: link clock idle low, toggles only inside a frame
// Notes: idle data line shows the inverse of the last bit sent
`timescale 1ns/10ps
module hbc_host (
    output logic sclk_out,
    output logic cs_n_out,
    output logic mosi_out,
    input wire logic miso_in
);
    logic [15:0] reply;
    // idle levels before the first frame
    initial begin
        sclk_out = 1'h0;
        cs_n_out = 1'h1;
        mosi_out = 1'h0;
        reply = 16'h0000;
    end
    // one frame, msb first; reply of the previous frame comes back
    task automatic xfer(input logic [15:0] w);
        #7 cs_n_out = 1'h0;
        for (int i = 15; i >= 0; i--) begin
            mosi_out = w[i];
            #80 sclk_out = 1'h1;
            #80 sclk_out = 1'h0;
            reply[i] = miso_in;
        end
        #80 cs_n_out = 1'h1;
        mosi_out = ~w[0];
        // gap lets the reply snapshot settle
        #600;
    endtask : xfer
endmodule : hbc_host

// ---- verification/hbc_top_tb_top.sv ----
// Purpose: self-checking bench of the bridge control block
// Assumes: host model on the link, pins and comparators driven here
// Notes: short detectors pulsed once each in the status test; expectations travel in a queue
`timescale 1ns/10ps
module hbc_top_tb_top;
    import hbc_pkg::*;
    // ****
    // wiring
    // ****
    localparam logic [12:0] DEF_CFG = 13'h0D98; // configuration word right after reset
    logic clk_in = 1'h0;
    logic resetn_in, wake, shut, pa, pb, uv, ov, oc, warn, sa, sb;
    logic sclk, cs_n, mosi, miso, a_hs, a_ls, b_hs, b_ls, half, fault_n;
    logic [1:0] cap;
    logic [2:0] edg;
    logic [18:0] q[$];
    logic [31:0] r;
    int fail_count = 0;
    int num_checks = 0;
    int n;
    event obs;
    always #25 clk_in = ~clk_in;
    hbc_host host (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi), .miso_in(miso));
    hbc_top dut (.clk_in(clk_in), .resetn_in(resetn_in), .sclk_in(sclk), .spi_cs_n_in(cs_n),
        .spi_mosi_in(mosi), .spi_miso_out(miso), .wake_pin_in(wake), .shutoff_pin_in(shut),
        .drive_pin_a_in(pa), .drive_pin_b_in(pb), .uv_cmp_in(uv), .ov_cmp_in(ov), .oc_cmp_in(oc),
        .heat_warning_state_in(warn), .short_a_in(sa), .short_b_in(sb), .leg_a_hs_out(a_hs),
        .leg_a_ls_out(a_ls), .leg_b_hs_out(b_hs), .leg_b_ls_out(b_ls), .half_threshold_out(half),
        .current_cap_threshold_out(cap), .edge_speed_out(edg), .fault_pin_n_out(fault_n));
    task automatic tick(input int c);
        repeat (c) @(posedge clk_in);
    endtask : tick
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : results
    // note an expectation, let the watcher compare, resume on an edge
    task automatic chk(input logic [2:0] k, input logic [15:0] v);
        q.push_back({k, v});
        #5 -> obs;
        @(posedge clk_in);
    endtask : chk
    task automatic wcfg(input logic [12:0] c);
        host.xfer({1'h1, ADDR_CFG, c});
        tick(10);
    endtask : wcfg
    // order: wake, shutoff, drive a, drive b
    task automatic pins(input logic [3:0] v);
        @(posedge clk_in);
        {wake, shut, pa, pb} <= v;
        tick(8);
    endtask : pins
    // leg enables {a_hs, a_ls, b_hs, b_ls} for a mode and two inputs
    function automatic logic [3:0] legs(input logic full, input logic a, input logic b);
        if (!full) return {a, ~a, b, ~b};
        if (!b) return 4'hA;
        return {a, ~a, ~a, a};
    endfunction : legs
    // watcher takes the oldest note whenever a result is due
    always @(obs) begin : watch
        logic [18:0] e;
        e = q.pop_front();
        case (e[18:16])
            3'h0: check({12'h000, a_hs, a_ls, b_hs, b_ls}, e[15:0]);
            3'h1: check(host.reply, e[15:0]);
            3'h2: check({15'h0000, fault_n}, e[15:0]);
            3'h3: check({15'h0000, half}, e[15:0]);
            default: check({11'h000, cap, edg}, e[15:0]);
        endcase
    end
    // ****
    // tests
    // ****
    initial begin
        {resetn_in, wake, shut, pa, pb, ov, oc, warn, sa, sb} = 10'h000;
        uv = 1'h1;
        r = $urandom(32'hC792);
        tick(12);
        resetn_in <= 1'h1;
        tick(3);
        chk(3'h0, 16'h0000);
        chk(3'h4, 16'h000C);
        uv <= 1'h0;
        tick(230);
        pins(4'hB);
        chk(3'h0, 16'h0009);
        chk(3'h2, 16'h0001);
        chk(3'h3, 16'h0000);
        host.xfer(16'h6000);
        host.xfer(16'h6000);
        chk(3'h1, {3'h3, DEF_CFG});
        $display("test reset done");
        for (int m = 0; m < 2; m++) begin
            wcfg({DEF_CFG[12:4], m[0], DEF_CFG[2:0]});
            for (int v = 0; v < 4; v++) begin
                pins({2'h2, v[1:0]});
                chk(3'h0, {12'h000, legs(m[0], v[1], v[0])});
            end
        end
        repeat (4) begin
            r = $urandom;
            wcfg({DEF_CFG[12:3], 1'h1, r[1:0]});
            pins({2'h2, r[3:2]});
            chk(3'h0, {12'h000, legs(1'h1, r[0], r[1])});
        end
        $display("test decode done");
        wcfg({DEF_CFG[12:5], 1'h0, DEF_CFG[3:0]});
        chk(3'h0, 16'h0000);
        wcfg(DEF_CFG);
        pins(4'h3);
        chk(3'h0, 16'h0000);
        pins(4'hF);
        chk(3'h0, 16'h0000);
        pins(4'hB);
        chk(3'h0, 16'h0009);
        $display("test gating done");
        ov <= 1'h1;
        tick(40);
        ov <= 1'h0;
        tick(3);
        ov <= 1'h1;
        tick(40);
        chk(3'h0, 16'h0009);
        tick(40);
        chk(3'h0, 16'h000A);
        chk(3'h2, 16'h0000);
        ov <= 1'h0;
        tick(10);
        chk(3'h0, 16'h0009);
        chk(3'h2, 16'h0000);
        pins(4'hF);
        pins(4'hB);
        chk(3'h2, 16'h0001);
        wcfg({DEF_CFG[12:4], 1'h0, DEF_CFG[2:0]});
        pins(4'hA);
        ov <= 1'h1;
        tick(80);
        chk(3'h0, 16'h0009);
        ov <= 1'h0;
        wcfg(DEF_CFG);
        pins(4'hB);
        $display("test overvoltage done");
        oc <= 1'h1;
        tick(10);
        chk(3'h0, 16'h0000);
        oc <= 1'h0;
        tick(700);
        chk(3'h0, 16'h0009);
        wcfg({DEF_CFG[12:11], 1'h0, DEF_CFG[9:0]});
        oc <= 1'h1;
        tick(10);
        chk(3'h0, 16'h0009);
        oc <= 1'h0;
        wcfg(DEF_CFG);
        $display("test limit done");
        uv <= 1'h1;
        tick(100);
        uv <= 1'h0;
        tick(10);
        chk(3'h0, 16'h0009);
        uv <= 1'h1;
        tick(250);
        chk(3'h0, 16'h0000);
        uv <= 1'h0;
        tick(100);
        chk(3'h0, 16'h0000);
        for (n = 0; n < 300 && {a_hs, a_ls, b_hs, b_ls} == 4'h0; n++) tick(1);
        if (n == 300) begin
            fail_count++;
            results();
        end
        chk(3'h0, 16'h0009);
        $display("test undervoltage done");
        warn <= 1'h1;
        tick(8);
        chk(3'h3, 16'h0001);
        warn <= 1'h0;
        tick(8);
        chk(3'h3, 16'h0000);
        r = $urandom;
        wcfg({2'h0, DEF_CFG[10], r[4:0], DEF_CFG[4:0]});
        chk(3'h3, 16'h0001);
        chk(3'h4, {11'h000, r[4:0]});
        $display("test derate done");
        sb <= 1'h1;
        tick(8);
        sb <= 1'h0;
        tick(8);
        chk(3'h0, 16'h0000);
        pins(4'hF);
        pins(4'hB);
        chk(3'h0, 16'h0009);
        wcfg({DEF_CFG[12:4], 1'h0, DEF_CFG[2:0]});
        sa <= 1'h1;
        tick(8);
        sa <= 1'h0;
        tick(8);
        chk(3'h0, 16'h0002);
        wcfg(DEF_CFG);
        chk(3'h0, 16'h0000);
        pins(4'hF);
        pins(4'hB);
        host.xfer(16'h8000);
        host.xfer(16'h2000);
        host.xfer(16'h2000);
        chk(3'h1, 16'h2800);
        chk(3'h2, 16'h0000);
        host.xfer(16'hA800);
        chk(3'h2, 16'h0001);
        $display("test status done");
        results();
    end
endmodule : hbc_top_tb_top
